// ### aboe_alu.sv
/*
 * aboe_alu: combinational adder and single-bit modifier.
 * assumes operands are stable for the whole instruction cycle.
 */
`timescale 1ns/1ps
module aboe_alu #(
   parameter int DATA_W = 8
) (
   // add operands
   input  wire logic [DATA_W-1:0] i_work,
   input  wire logic [DATA_W-1:0] i_file,
   // bit operation
   input  wire logic [2:0]        i_bit_sel,
   input  wire logic              i_bit_val,
   // results
   output logic [DATA_W-1:0]      o_sum,
   output logic                   o_carry,
   output logic                   o_digit_carry,
   output logic                   o_zero,
   output logic [DATA_W-1:0]      o_bit_mod,
   output logic                   o_bit_cur
);
   logic [DATA_W:0] sum_ext;
   logic [4:0]      nib_ext;

   always_comb begin
      sum_ext       = {1'b0, i_work} + {1'b0, i_file};
      nib_ext       = {1'b0, i_work[3:0]} + {1'b0, i_file[3:0]};
      o_sum         = sum_ext[DATA_W-1:0];
      o_carry       = sum_ext[DATA_W];
      o_digit_carry = nib_ext[aboe_pkg::NIB_POS+1];
      o_zero        = (sum_ext[DATA_W-1:0] == '0);
      o_bit_mod     = i_file;
      o_bit_mod[i_bit_sel] = i_bit_val;
      o_bit_cur     = i_file[i_bit_sel];
   end
endmodule // aboe_alu

// ### aboe_exec.sv
/*
 * aboe_exec: executes add-work-to-file, bit-clear, bit-set and
 * bit-test-skip-if-clear, one instruction word per clock.
 * assumes the fetch stage presents the word with a valid strobe and the
 * file space answers reads combinationally at o_faddr.
 * assumes i_nrst is released away from the rising clock edge.
 */
// Overview of operation
// RL1: the add opcode sums the working register and the file register and updates carry, digit carry and zero.
// RL2: with the destination bit clear the sum goes to the working register only.
// RL3: with the destination bit set the sum is written back to file address 0 to 127.
// RL4: bit clear forces the selected bit to zero and leaves all flags alone.
// RL5: bit set forces the selected bit to one and leaves all flags alone.
// RL6: bit test discards the next fetched word when the bit is zero, taking two cycles, else one.
// RL7: add, bit clear and bit set are single-word, single-cycle instructions.
`timescale 1ns/1ps
module aboe_exec #(
   parameter int DATA_W = aboe_pkg::DATA_W
) (
   // clock and reset
   input  wire logic                        i_mclk,
   input  wire logic                        i_nrst,
   // instruction stream
   input  wire logic [aboe_pkg::INSN_W-1:0] i_insn,
   input  wire logic                        i_insn_vld,
   // file register space
   output logic [aboe_pkg::FADDR_W-1:0]     o_faddr,
   input  wire logic [DATA_W-1:0]           i_frdata,
   output logic                             o_fwe,
   output logic [DATA_W-1:0]                o_fwdata,
   // core state
   output logic [DATA_W-1:0]                o_work,
   output logic                             o_carry_flag,
   output logic                             o_digit_carry_flag,
   output logic                             o_zero_flag,
   output logic                             o_skip_busy
);
   // ------------------------------------------------------------------
   // decode
   // ------------------------------------------------------------------
   // no-operation covers every word outside the four handled patterns
   typedef enum logic [2:0] {
      ABOE_NONE,
      ABOE_ADD,
      ABOE_BCLR,
      ABOE_BSET,
      ABOE_BTSC
   } aboe_op_e;

   // one decoder feeds every strobe, so the opcode patterns live in one place
   function automatic aboe_op_e aboe_decode(
      input logic [aboe_pkg::INSN_W-1:0] insn);
      aboe_op_e op;
      op = ABOE_NONE;
      if (insn[13:8] == aboe_pkg::OPC_ADD) begin
         op = ABOE_ADD;   // RL1
      end else begin
         case (insn[13:10])
            aboe_pkg::OPC_BCLR: op = ABOE_BCLR;
            aboe_pkg::OPC_BSET: op = ABOE_BSET;
            aboe_pkg::OPC_BTSC: op = ABOE_BTSC;
            default:            op = ABOE_NONE;
         endcase
      end
      return op;
   endfunction

   // the sequencer spends at most one extra cycle on a skip
   typedef enum {
      ABOE_RUN,
      ABOE_DISCARD
   } aboe_state_e;

   aboe_op_e          op;
   aboe_state_e       state_q;
   aboe_state_e       state_d;
   logic [DATA_W-1:0] work_q;
   logic [DATA_W-1:0] work_d;
   logic [2:0]        flags_q;
   logic [2:0]        flags_d;
   logic [DATA_W-1:0] sum;
   logic [DATA_W-1:0] bit_mod;
   logic              c_new;
   logic              dc_new;
   logic              z_new;
   logic              bit_cur;
   logic              fwe_d;
   logic              fwe_q;
   logic [DATA_W-1:0] fwdata_d;
   logic [DATA_W-1:0] fwdata_q;
   logic              active;
   logic              do_add;
   logic              do_bit_wr;
   logic              do_test;

   assign active  = i_insn_vld && (state_q == ABOE_RUN);
   assign op      = aboe_decode(i_insn);
   assign o_faddr = i_insn[aboe_pkg::FADDR_W-1:0];   // RL3

   aboe_alu #(
      .DATA_W        (DATA_W)
   ) u_alu (
      .i_work        (work_q),
      .i_file        (i_frdata),
      .i_bit_sel     (i_insn[aboe_pkg::BIT_LSB +: 3]),
      .i_bit_val     (op == ABOE_BSET),
      .o_sum         (sum),
      .o_carry       (c_new),
      .o_digit_carry (dc_new),
      .o_zero        (z_new),
      .o_bit_mod     (bit_mod),
      .o_bit_cur     (bit_cur)
   );

   // ------------------------------------------------------------------
   // executed strobes
   // ------------------------------------------------------------------
   // a word acts only in a run cycle; an invalid word, an unknown opcode
   // and the discard cycle all fall through as no-operations, so no
   // register below needs its own validity test
   always_comb begin
      do_add    = active && (op == ABOE_ADD);                   // RL1
      do_bit_wr = active && ((op == ABOE_BCLR) || (op == ABOE_BSET));
      do_test   = active && (op == ABOE_BTSC);                  // RL6
   end

   // ------------------------------------------------------------------
   // skip sequencer
   // ------------------------------------------------------------------
   // the word fetched behind a taken test is dropped by one discard cycle
   // rather than by stalling the fetch side
   always_comb begin
      state_d = state_q;
      case (state_q)
         ABOE_RUN: begin
            if (do_test && !bit_cur) begin
               state_d = ABOE_DISCARD;                        // RL6
            end
         end
         ABOE_DISCARD: begin
            // the prefetched word is dropped: a no-operation cycle
            state_d = ABOE_RUN;                               // RL6
         end
         default: begin
            state_d = ABOE_RUN;
         end
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_q <= ABOE_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   // ------------------------------------------------------------------
   // working register and status flags
   // ------------------------------------------------------------------
   // only an executed add loads the flags; bit operations leave them be
   always_comb begin
      work_d  = work_q;
      flags_d = flags_q;
      if (do_add) begin
         flags_d = {z_new, dc_new, c_new};                    // RL1
         if (!i_insn[aboe_pkg::DEST_POS]) begin
            work_d = sum;                                     // RL2
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin   // RL7
      if (!i_nrst) begin
         work_q  <= aboe_pkg::W_RST;
         flags_q <= aboe_pkg::FLAGS_RST;
      end else begin
         work_q  <= work_d;
         flags_q <= flags_d;
      end
   end

   // ------------------------------------------------------------------
   // file write port
   // ------------------------------------------------------------------
   // the write is registered so all single-cycle ops retire at one edge;
   // the cost is that a word reading the same address in the very next
   // cycle sees the old value unless the file space forwards the write
   always_comb begin
      fwe_d    = 1'b0;
      fwdata_d = fwdata_q;
      if (do_add && i_insn[aboe_pkg::DEST_POS]) begin
         fwe_d    = 1'b1;                                     // RL3
         fwdata_d = sum;
      end else if (do_bit_wr) begin
         fwe_d    = 1'b1;                                     // RL4
         fwdata_d = bit_mod;                                  // RL5
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin   // RL7
      if (!i_nrst) begin
         fwe_q    <= 1'b0;
         fwdata_q <= '0;
      end else begin
         fwe_q    <= fwe_d;
         fwdata_q <= fwdata_d;
      end
   end

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   // data outputs come straight from flip-flops
   assign o_fwe              = fwe_q;
   assign o_fwdata           = fwdata_q;
   assign o_work             = work_q;
   assign o_carry_flag       = flags_q[0];
   assign o_digit_carry_flag = flags_q[1];
   assign o_zero_flag        = flags_q[2];
   assign o_skip_busy        = (state_q == ABOE_DISCARD);
endmodule // aboe_exec

// ### aboe_exec_properties.sv
/* aboe_exec_properties: port-level checks of aboe_exec.
   assumes the file space answers reads combinationally. */
`timescale 1ns/1ps
module aboe_exec_properties #(parameter int DATA_W = 8) (
   // clock, reset, inputs
   input wire logic              i_mclk,
   input wire logic              i_nrst,
   input wire logic [13:0]       i_insn,
   input wire logic              i_insn_vld,
   input wire logic [DATA_W-1:0] i_frdata,
   // outputs
   input wire logic [6:0]        o_faddr,
   input wire logic              o_fwe,
   input wire logic [DATA_W-1:0] o_fwdata,
   input wire logic [DATA_W-1:0] o_work,
   input wire logic              o_carry_flag,
   input wire logic              o_digit_carry_flag,
   input wire logic              o_zero_flag,
   input wire logic              o_skip_busy
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_nrst);
   wire [8:0] sum = o_work + i_frdata;
   wire [4:0] hs = o_work[3:0] + i_frdata[3:0];
   wire [7:0] s8 = sum[7:0];
   wire [2:0] aflg = {sum[8], hs[4], s8 == 8'h00};
   wire [2:0] flg = {o_carry_flag, o_digit_carry_flag, o_zero_flag};
   wire [7:0] msk = 8'h01 << i_insn[9:7];
   wire [7:0] clr = i_frdata & ~msk;
   wire [7:0] set = i_frdata | msk;
   wire bz = (i_frdata & msk) == 8'h00;
   wire tk = i_insn_vld && !o_skip_busy;
   wire add = tk && i_insn[13:8] == aboe_pkg::OPC_ADD;
   wire bclr = tk && i_insn[13:10] == aboe_pkg::OPC_BCLR;
   wire bset = tk && i_insn[13:10] == aboe_pkg::OPC_BSET;
   wire btsc = tk && i_insn[13:10] == aboe_pkg::OPC_BTSC;
   // a discard lasts exactly one cycle
   sequence s_skip; o_skip_busy ##1 !o_skip_busy; endsequence
   AST_ADD_FLAGS: assert property (add |=> flg == $past(aflg))
      else $error("add flags wrong");
   AST_ADD_WORK: assert property (add && !i_insn[7] |=>
      !o_fwe && o_work == $past(s8)) else $error("add to work wrong");
   AST_ADD_FILE: assert property (add && i_insn[7] |=> o_fwe &&
      o_fwdata == $past(s8) && $stable(o_work)) else $error("add to file");
   AST_BIT_CLR: assert property (bclr |=> o_fwe &&
      o_fwdata == $past(clr) && $stable(flg)) else $error("clear wrong");
   AST_BIT_SET: assert property (bset |=> o_fwe &&
      o_fwdata == $past(set) && $stable(flg)) else $error("set wrong");
   AST_SKIP_TAKEN: assert property (btsc && bz |=> s_skip)
      else $error("skip not taken");
   AST_SKIP_NOT: assert property (btsc && !bz |=> !o_skip_busy)
      else $error("skip taken on set bit");
   AST_SKIP_DROP: assert property (o_skip_busy |=> !o_fwe &&
      $stable(o_work) && $stable(flg)) else $error("dropped word ran");
   AST_ONE_CYCLE: assert property (add || bclr || bset |=>
      !o_skip_busy) else $error("single-cycle op stalled");
   AST_FADDR: assert property (o_faddr == i_insn[6:0])
      else $error("file address wrong");
   AST_NOP_HOLD: assert property (!(add || bclr || bset || btsc) |=>
      !o_fwe && $stable(o_work) && $stable(flg))
      else $error("no-operation changed state");
endmodule // aboe_exec_properties
bind aboe_exec aboe_exec_properties #(.DATA_W(DATA_W)) u_props (
   .i_mclk(i_mclk), .i_nrst(i_nrst), .i_insn(i_insn),
   .i_insn_vld(i_insn_vld), .i_frdata(i_frdata), .o_faddr(o_faddr),
   .o_fwe(o_fwe), .o_fwdata(o_fwdata), .o_work(o_work),
   .o_carry_flag(o_carry_flag), .o_digit_carry_flag(o_digit_carry_flag),
   .o_zero_flag(o_zero_flag), .o_skip_busy(o_skip_busy));

// ### aboe_pkg.sv
/*
 * aboe_pkg: shared constants for the add and bit-operation executor.
 * assumes a 14-bit instruction word and an 8-bit data path.
 */
package aboe_pkg;
   // ------------------------------------------------------------------
   // widths and opcode patterns
   // ------------------------------------------------------------------
   localparam int          INSN_W      = 14;
   localparam int          DATA_W      = 8;
   localparam int          FADDR_W     = 7;
   localparam logic [5:0]  OPC_ADD     = 6'h07;   // 00 0111
   localparam logic [3:0]  OPC_BCLR    = 4'h4;    // 01 00
   localparam logic [3:0]  OPC_BSET    = 4'h5;    // 01 01
   localparam logic [3:0]  OPC_BTSC    = 4'h6;    // 01 10
   // ------------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------------
   localparam int          DEST_POS    = 7;
   localparam int          BIT_LSB     = 7;
   localparam int          NIB_POS     = 3;   // digit-carry comes from bit 3
   localparam logic [7:0]  W_RST       = 8'h00;
   localparam logic [2:0]  FLAGS_RST   = 3'h0;
   localparam int          SKIP_CYCLES = 2;
endpackage

// ### test_add_and_bit_ops_exec.sv
/* test_add_and_bit_ops_exec: instruction stream checked against a model.
   assumes the bench owns the file space and answers reads at once. */
`timescale 1ns/1ps
module test_add_and_bit_ops_exec;
   logic        i_mclk = 0, i_nrst = 0, i_insn_vld = 0, o_fwe, o_skip_busy;
   logic        o_carry_flag, o_digit_carry_flag, o_zero_flag, skp = 0;
   logic [13:0] i_insn = 14'h0000;
   logic [6:0]  o_faddr;
   logic [7:0]  i_frdata, o_fwdata, o_work, w = 8'h00, mem [128];
   logic [2:0]  fl = 3'h0;
   logic [20:0] expq [$], e, seen;
   logic [31:0] r;
   int          mismatches = 0, cmp_count = 0;
   always #50 i_mclk = ~i_mclk;
   assign i_frdata = mem[o_faddr];
   aboe_exec uut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_insn(i_insn),
      .i_insn_vld(i_insn_vld), .o_faddr(o_faddr), .i_frdata(i_frdata),
      .o_fwe(o_fwe), .o_fwdata(o_fwdata), .o_work(o_work),
      .o_carry_flag(o_carry_flag), .o_digit_carry_flag(o_digit_carry_flag),
      .o_zero_flag(o_zero_flag), .o_skip_busy(o_skip_busy));
   task check(input logic [20:0] sn, input logic [20:0] ex);
      cmp_count++;
      if (sn !== ex) begin
         mismatches++;
         $display("BAD outputs exp %h seen %h", ex, sn);
      end
   endtask
   task finish_test;
      if (expq.size() != 0) mismatches++;
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // one cycle: drive, predict, then commit the model after the edge
   task cyc(input logic v, input logic [13:0] ins);
      logic [7:0] f, nw, m;
      logic [8:0] s;
      logic [4:0] h;
      logic [2:0] nf;
      logic       we, ns;
      @(negedge i_mclk);
      i_insn = ins;
      i_insn_vld = v;
      f = mem[ins[6:0]];
      m = 8'h01 << ins[9:7];
      s = w + f;
      h = w[3:0] + f[3:0];
      {nw, nf, we, ns} = {w, fl, 2'b00};
      if (v && !skp) begin
         if (ins[13:8] == aboe_pkg::OPC_ADD) begin
            nf = {s[8], h[4], s[7:0] == 8'h00};
            if (ins[7]) {we, f} = {1'b1, s[7:0]};
            else nw = s[7:0];
         end
         else if (ins[13:10] == aboe_pkg::OPC_BCLR) {we, f} = {1'b1, f & ~m};
         else if (ins[13:10] == aboe_pkg::OPC_BSET) {we, f} = {1'b1, f | m};
         else if (ins[13:10] == aboe_pkg::OPC_BTSC) ns = (f & m) == 8'h00;
      end
      expq.push_back({nw, nf, we, f, ns});
      @(posedge i_mclk);
      #1;
      {w, fl, skp} = {nw, nf, ns};
      if (we) mem[ins[6:0]] = f;
   endtask
   always @(posedge i_mclk) if (i_nrst && expq.size() > 0) begin
      #2;
      e = expq.pop_front();
      seen = {o_work, o_carry_flag, o_digit_carry_flag, o_zero_flag, o_fwe,
              o_fwdata, o_skip_busy};
      if (!e[9]) seen[8:1] = e[8:1];
      check(seen, e);
   end
   initial begin
      void'($urandom(40));
      for (int i = 0; i < 128; i++) mem[i] = 8'($urandom);
      repeat (2) @(posedge i_mclk);
      @(negedge i_mclk) i_nrst = 1;
      // every bit index: set, test, clear, test, then an add that is dropped
      for (int b = 0; b < 8; b++) begin
         cyc(1, {aboe_pkg::OPC_BSET, 3'(b), 7'h7f});
         cyc(1, {aboe_pkg::OPC_BTSC, 3'(b), 7'h7f});
         cyc(1, {aboe_pkg::OPC_BCLR, 3'(b), 7'h7f});
         cyc(1, {aboe_pkg::OPC_BTSC, 3'(b), 7'h7f});
         cyc(1, {aboe_pkg::OPC_ADD, b[0], 7'h00});
      end
      $display("test 1 done");
      // random stream, narrow addresses to force back-to-back reuse
      repeat (400) begin
         r = $urandom;
         if (!r[26]) r[6:3] = 4'h0;
         if (r[31:30] == 2'b00) r[13:8] = aboe_pkg::OPC_ADD;
         else r[13:10] = {2'b01, r[31:30] - 2'b01};
         // now and then an unknown opcode, which must act as a no-op
         if (r[25:23] == 3'h7) r[13] = 1'b1;
         cyc(r[29:27] != 3'h0, r[13:0]);
      end
      // let the monitor compare the last result before closing
      @(negedge i_mclk);
      $display("test 2 done");
      finish_test;
   end
   initial begin
      #100000;
      mismatches++;
      finish_test;
   end
endmodule // test_add_and_bit_ops_exec
